/* core/ddrp_pkg.sv */
package ddrp_pkg;

    localparam int ROW_W = 13;
    localparam int BANK_W = 2;
    localparam int NBANK = 4;
    localparam int DQ_W = 8;
    localparam int COL_KEEP = 4;
    localparam int MEM_COLS = 16;
    localparam int MEM_W = 6;
    localparam int BURST_LEN = 4;
    localparam int MR_NUM = 4;

    // address bit positions
    localparam int AP_BIT = 10;
    localparam int EMR_DQS_SE_BIT = 10;
    localparam int EMR_RDQS_BIT = 11;

    localparam logic [BANK_W-1:0] MR_IDX_EMR1 = 2'h1;
    localparam logic [2:0] BURST_CNT = 3'h4;
    localparam logic [1:0] FIFO_DEPTH = 2'h2;

    typedef enum logic [2:0] {
        DDRP_CMD_NOP,
        DDRP_CMD_ACT,
        DDRP_CMD_RD,
        DDRP_CMD_WR,
        DDRP_CMD_PRE,
        DDRP_CMD_MODE,
        DDRP_CMD_REF,
        DDRP_CMD_DESEL
    } ddrp_cmd_e;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic cke;
        logic odt;
        logic [BANK_W-1:0] ba;
        logic [ROW_W-1:0] addr;
    } ddrp_pins_s;

    typedef struct packed {
        logic [DQ_W-1:0] dq;
        logic dqs;
        logic dqs_n;
        logic dm;
    } ddrp_data_s;

    typedef struct packed {
        logic [DQ_W-1:0] dq;
        logic dq_oe;
        logic dqs;
        logic dqs_n;
        logic dqs_oe;
        logic dqs_n_oe;
        logic rdqs;
        logic rdqs_n;
        logic rdqs_oe;
        logic rdqs_n_oe;
        logic odt_on;
        logic clk_on;
    } ddrp_out_s;

    typedef struct packed {
        logic ck_m;
        logic ck_q;
        logic ck_d;
        logic ckn_m;
        logic ckn_q;
        ddrp_pins_s pins_m;
        ddrp_pins_s pins_q;
        ddrp_data_s dat_m;
        ddrp_data_s dat_q;
        logic dqs_d;
        logic [MR_NUM-1:0][ROW_W-1:0] mr;
        logic [NBANK-1:0] bank_open;
        logic [NBANK-1:0][ROW_W-1:0] open_row;
        logic [NBANK*MEM_COLS-1:0][DQ_W-1:0] mem;
        logic [2:0] rd_left;
        logic [BANK_W-1:0] rd_bank;
        logic [COL_KEEP-1:0] rd_col;
        logic rd_ap;
        logic rd_run;
        logic [2:0] wr_left;
        logic [BANK_W-1:0] wr_bank;
        logic [COL_KEEP-1:0] wr_col;
        logic wr_ap;
        logic [1:0][DQ_W-1:0] fifo;
        logic f_wp;
        logic f_rp;
        logic [1:0] f_cnt;
        ddrp_out_s out;
    } ddrp_state_s;

    localparam ddrp_state_s DDRP_STATE_RST = '0;

endpackage

/* core/ddrp_device.sv */
`timescale 1ns/1ps
// Summary of operation
// - activate opens 13-bit row in bank
// - column from A0-A3, A10 auto-precharge
// - bank bits select bank of command
// - bank bits select mode register written
// - termination on when ODT registered high
// - device drives edge-aligned DQS with reads
// - complementary DQS only in differential mode
// - chip select high masks every command
// - command decoded from CS RAS CAS WE
// - masked write beats are not stored
// - mask sampled on both strobe edges
// - RDQS driven on reads, ignored on writes
// - RDQS enabled disables write masking
// - complementary RDQS needs RDQS and differential
// - command, CKE and ODT inputs sampled on rising clock crossing
// - read data on both clock crossings
// - CKE registered high enables clocking circuitry
module ddrp_device
    import ddrp_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ck_i,
    input wire logic ck_n_i,
    input wire logic cke_i,
    input wire logic cs_n_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire logic [BANK_W-1:0] ba_i,
    input wire logic [ROW_W-1:0] addr_i,
    input wire logic odt_i,
    input wire logic [DQ_W-1:0] dq_i,
    output logic [DQ_W-1:0] dq_o,
    output logic dq_oe_o,
    input wire logic dqs_i,
    input wire logic dqs_n_i,
    output logic dqs_o,
    output logic dqs_oe_o,
    output logic dqs_n_o,
    output logic dqs_n_oe_o,
    input wire logic dm_rdqs_i,
    output logic rdqs_o,
    output logic rdqs_oe_o,
    output logic rdqs_n_o,
    output logic rdqs_n_oe_o,
    output logic odt_on_o,
    output logic clk_on_o
);

    ddrp_state_s st;
    ddrp_state_s next_st;

    function automatic ddrp_cmd_e cmd_decode(input ddrp_pins_s p);
        ddrp_cmd_e c;
        c = DDRP_CMD_NOP;
        if (p.cs_n) begin
            c = DDRP_CMD_DESEL;
        end else begin
            unique case ({p.ras_n, p.cas_n, p.we_n})
                3'h7: c = DDRP_CMD_NOP;
                3'h3: c = DDRP_CMD_ACT;
                3'h5: c = DDRP_CMD_RD;
                3'h4: c = DDRP_CMD_WR;
                3'h2: c = DDRP_CMD_PRE;
                3'h0: c = DDRP_CMD_MODE;
                3'h1: c = DDRP_CMD_REF;
                3'h6: c = DDRP_CMD_NOP;
            endcase
        end
        return c;
    endfunction

    function automatic logic [MEM_W-1:0] mem_idx(
        input logic [BANK_W-1:0] bank,
        input logic [COL_KEEP-1:0] col
    );
        return {bank, col};
    endfunction

    function automatic logic [COL_KEEP-1:0] col_step(input logic [COL_KEEP-1:0] col);
        // burst wraps inside its aligned group of four
        return {col[COL_KEEP-1:2], col[1:0] + 2'h1};
    endfunction

    logic ck_rise;
    logic ck_fall;
    logic diff_on;
    logic rdqs_en;
    logic dqs_rise;
    logic dqs_fall;
    logic push;
    logic pop;
    logic drain_edge;
    ddrp_cmd_e cmd;
    ddrp_pins_s p;

    always_comb begin
        next_st = st;
        ck_rise = 1'b0;
        ck_fall = 1'b0;
        diff_on = 1'b0;
        rdqs_en = 1'b0;
        dqs_rise = 1'b0;
        dqs_fall = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        drain_edge = 1'b0;
        cmd = DDRP_CMD_NOP;
        p = st.pins_q;

        // two-stage synchronisers for every pin
        next_st.ck_m = ck_i;
        next_st.ck_q = st.ck_m;
        next_st.ck_d = st.ck_q;
        next_st.ckn_m = ck_n_i;
        next_st.ckn_q = st.ckn_m;
        next_st.pins_m = {cs_n_i, ras_n_i, cas_n_i, we_n_i, cke_i, odt_i, ba_i, addr_i};
        next_st.pins_q = st.pins_m;
        next_st.dat_m = {dq_i, dqs_i, dqs_n_i, dm_rdqs_i};
        next_st.dat_q = st.dat_m;
        next_st.dqs_d = st.dat_q.dqs;

        // crossing: true clock up, complement down
        ck_rise = st.ck_q & ~st.ck_d & ~st.ckn_q;
        ck_fall = ~st.ck_q & st.ck_d & st.ckn_q;

        diff_on = ~st.mr[MR_IDX_EMR1][EMR_DQS_SE_BIT];
        rdqs_en = st.mr[MR_IDX_EMR1][EMR_RDQS_BIT];

        // complement strobe only qualifies edges in differential mode
        dqs_rise = st.dat_q.dqs & ~st.dqs_d & (~diff_on | ~st.dat_q.dqs_n);
        dqs_fall = ~st.dat_q.dqs & st.dqs_d & (~diff_on | st.dat_q.dqs_n);

        if (ck_rise) begin
            next_st.out.clk_on = p.cke;
            next_st.out.odt_on = p.odt;
            if (p.cke) begin
                cmd = cmd_decode(p);
            end
        end

        unique case (cmd)
            DDRP_CMD_ACT: begin
                if (!st.bank_open[p.ba]) begin
                    next_st.bank_open[p.ba] = 1'b1;
                    next_st.open_row[p.ba] = p.addr;
                end
            end
            DDRP_CMD_RD: begin
                // a new burst is refused while one is in flight
                if (st.bank_open[p.ba] && st.rd_left == 3'h0 && st.wr_left == 3'h0) begin
                    next_st.rd_left = BURST_CNT;
                    next_st.rd_bank = p.ba;
                    next_st.rd_col = p.addr[COL_KEEP-1:0];
                    next_st.rd_ap = p.addr[AP_BIT];
                end
            end
            DDRP_CMD_WR: begin
                if (st.bank_open[p.ba] && st.rd_left == 3'h0 && st.wr_left == 3'h0) begin
                    next_st.wr_left = BURST_CNT;
                    next_st.wr_bank = p.ba;
                    next_st.wr_col = p.addr[COL_KEEP-1:0];
                    next_st.wr_ap = p.addr[AP_BIT];
                end
            end
            DDRP_CMD_PRE: begin
                if (p.addr[AP_BIT]) begin
                    next_st.bank_open = '0;
                end else begin
                    next_st.bank_open[p.ba] = 1'b0;
                end
            end
            DDRP_CMD_MODE: begin
                next_st.mr[p.ba] = p.addr;
            end
            DDRP_CMD_REF,
            DDRP_CMD_NOP,
            DDRP_CMD_DESEL: begin
                next_st.mr = st.mr;
            end
        endcase

        // write beats, one per strobe edge
        if ((dqs_rise || dqs_fall) && st.wr_left != 3'h0) begin
            // mask pin serves as read strobe when enabled
            if (!st.dat_q.dm || rdqs_en) begin
                next_st.mem[mem_idx(st.wr_bank, st.wr_col)] = st.dat_q.dq;
            end
            next_st.wr_col = col_step(st.wr_col);
            next_st.wr_left = st.wr_left - 3'h1;
            if (st.wr_left == 3'h1 && st.wr_ap) begin
                next_st.bank_open[st.wr_bank] = 1'b0;
            end
        end

        // read fill into the two-entry buffer, stalls when full
        if (st.rd_left != 3'h0 && st.f_cnt != FIFO_DEPTH) begin
            push = 1'b1;
            next_st.fifo[st.f_wp] = st.mem[mem_idx(st.rd_bank, st.rd_col)];
            next_st.f_wp = ~st.f_wp;
            next_st.rd_col = col_step(st.rd_col);
            next_st.rd_left = st.rd_left - 3'h1;
            if (st.rd_left == 3'h1 && st.rd_ap) begin
                next_st.bank_open[st.rd_bank] = 1'b0;
            end
        end

        // a burst starts on a rising crossing, then runs on both
        drain_edge = (ck_rise && st.f_cnt != 2'h0) || (st.rd_run && (ck_rise || ck_fall));
        if (drain_edge) begin
            if (st.f_cnt != 2'h0) begin
                pop = 1'b1;
                next_st.f_rp = ~st.f_rp;
                next_st.rd_run = 1'b1;
                next_st.out.dq = st.fifo[st.f_rp];
                next_st.out.dq_oe = 1'b1;
                next_st.out.dqs = ck_rise;
                next_st.out.dqs_oe = 1'b1;
                next_st.out.dqs_n = ~ck_rise;
                next_st.out.dqs_n_oe = diff_on;
                next_st.out.rdqs = ck_rise;
                next_st.out.rdqs_oe = rdqs_en;
                next_st.out.rdqs_n = ~ck_rise;
                next_st.out.rdqs_n_oe = rdqs_en & diff_on;
            end else begin
                next_st.rd_run = 1'b0;
                next_st.out.dq_oe = 1'b0;
                next_st.out.dqs_oe = 1'b0;
                next_st.out.dqs_n_oe = 1'b0;
                next_st.out.rdqs_oe = 1'b0;
                next_st.out.rdqs_n_oe = 1'b0;
            end
        end

        unique case ({push, pop})
            2'h2: next_st.f_cnt = st.f_cnt + 2'h1;
            2'h1: next_st.f_cnt = st.f_cnt - 2'h1;
            2'h0,
            2'h3: next_st.f_cnt = st.f_cnt;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st <= DDRP_STATE_RST;
        end else begin
            st <= next_st;
        end
    end

    assign dq_o = st.out.dq;
    assign dq_oe_o = st.out.dq_oe;
    assign dqs_o = st.out.dqs;
    assign dqs_oe_o = st.out.dqs_oe;
    assign dqs_n_o = st.out.dqs_n;
    assign dqs_n_oe_o = st.out.dqs_n_oe;
    assign rdqs_o = st.out.rdqs;
    assign rdqs_oe_o = st.out.rdqs_oe;
    assign rdqs_n_o = st.out.rdqs_n;
    assign rdqs_n_oe_o = st.out.rdqs_n_oe;
    assign odt_on_o = st.out.odt_on;
    assign clk_on_o = st.out.clk_on;

endmodule // ddrp_device

/* verif/ddrp_device_props.sv */
`timescale 1ns/1ps
module ddrp_device_props
    import ddrp_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic cke_i,
    input wire logic odt_i,
    input wire logic [DQ_W-1:0] dq_o,
    input wire logic dq_oe_o,
    input wire logic dqs_o,
    input wire logic dqs_oe_o,
    input wire logic dqs_n_o,
    input wire logic dqs_n_oe_o,
    input wire logic rdqs_o,
    input wire logic rdqs_oe_o,
    input wire logic rdqs_n_oe_o,
    input wire logic odt_on_o,
    input wire logic clk_on_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_oe_pair: assert property (dq_oe_o == dqs_oe_o)
        else $error("data and strobe enables differ");
    a_burst_len: assert property ($rose(dq_oe_o) |-> dqs_o ##1 dq_oe_o [*8])
        else $error("read burst too short or starts on fall");
    a_beat_edge: assert property (dq_oe_o && $past(dq_oe_o) && $changed(dq_o) |-> $changed(dqs_o))
        else $error("read data moved without strobe edge");
    a_strobe_cmp: assert property (dqs_n_oe_o |-> dqs_n_o == !dqs_o)
        else $error("complementary strobe not inverse");
    a_dqsn_mode: assert property (dqs_n_oe_o |-> dqs_oe_o)
        else $error("complementary strobe alone");
    a_rdqs_read: assert property (rdqs_oe_o |-> dq_oe_o && rdqs_o == dqs_o)
        else $error("read strobe outside read data");
    a_rdqsn_need: assert property (rdqs_n_oe_o |-> rdqs_oe_o && dqs_n_oe_o)
        else $error("complementary read strobe misused");
    // pins are held a whole link period, so four cycles back is inside it
    a_odt_follow: assert property ($changed(odt_on_o) |-> odt_on_o == $past(odt_i, 4))
        else $error("termination not following request");
    a_cke_follow: assert property ($changed(clk_on_o) |-> clk_on_o == $past(cke_i, 4))
        else $error("clocking not following enable");
endmodule // ddrp_device_props
bind ddrp_device ddrp_device_props u_props (.clk_i, .sys_rst_i, .cke_i, .odt_i, .dq_o, .dq_oe_o, .dqs_o,
    .dqs_oe_o, .dqs_n_o, .dqs_n_oe_o, .rdqs_o, .rdqs_oe_o, .rdqs_n_oe_o, .odt_on_o, .clk_on_o);

/* verif/ddrp_ctrl_model.sv */
`timescale 1ns/1ps
module ddrp_ctrl_model
    import ddrp_pkg::*;
(
    output logic ck_o,
    output logic ck_n_o,
    output ddrp_pins_s pins_o,
    output ddrp_data_s dat_o
);
    // free running link clock, phase unrelated to clk_i
    initial begin
        ck_o = 1'b0;
        #7;
        forever #160 ck_o = ~ck_o;
    end
    assign ck_n_o = ~ck_o;
    initial begin
        pins_o = '0;
        pins_o.cs_n = 1'b1;
        dat_o = '0;
        dat_o.dqs_n = 1'b1;
    end
    task automatic ctl(input logic cke, input logic odt);
        @(negedge ck_o);
        pins_o.cke = cke;
        pins_o.odt = odt;
    endtask
    // pins change on the falling crossing so the rising one sees them settled
    task automatic cmd(input logic [2:0] c, input logic [BANK_W-1:0] ba, input logic [ROW_W-1:0] a,
        input logic cs_n = 1'b0);
        @(negedge ck_o);
        pins_o.cs_n = cs_n;
        {pins_o.ras_n, pins_o.cas_n, pins_o.we_n} = c;
        pins_o.ba = ba;
        pins_o.addr = a;
        @(negedge ck_o);
        pins_o.cs_n = 1'b1;
        pins_o.addr = ~a;
    endtask
    task automatic wr(input logic [3:0][DQ_W-1:0] d, input logic [3:0] m);
        for (int i = 0; i < 4; i++) begin
            dat_o.dq = d[i];
            dat_o.dm = m[i];
            #80;
            dat_o.dqs = ~dat_o.dqs;
            dat_o.dqs_n = ~dat_o.dqs_n;
            #80;
        end
        dat_o.dq = ~d[3];
    endtask
endmodule // ddrp_ctrl_model

/* verif/ddr2_sdram_pin_interface_tb_top.sv */
`timescale 1ns/1ps
module ddr2_sdram_pin_interface_tb_top
    import ddrp_pkg::*;
;
    localparam logic [2:0] C_ACT = 3'h3;
    localparam logic [2:0] C_RD = 3'h5;
    localparam logic [2:0] C_WR = 3'h4;
    localparam logic [2:0] C_PRE = 3'h2;
    localparam logic [2:0] C_MODE = 3'h0;
    localparam logic [2:0] C_REF = 3'h1;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic ck, ck_n, dq_oe_o, dqs_o, dqs_oe_o, dqs_n_o, dqs_n_oe_o;
    logic rdqs_o, rdqs_oe_o, rdqs_n_o, rdqs_n_oe_o, odt_on_o, clk_on_o;
    logic [DQ_W-1:0] dq_o;
    ddrp_pins_s pins;
    ddrp_data_s dat;
    int err_count = 0;
    int n_checks = 0;
    always #20 clk_i = ~clk_i;
    ddrp_ctrl_model u_ctrl (.ck_o(ck), .ck_n_o(ck_n), .pins_o(pins), .dat_o(dat));
    ddrp_device DUT (.clk_i, .sys_rst_i, .ck_i(ck), .ck_n_i(ck_n), .cke_i(pins.cke), .cs_n_i(pins.cs_n),
        .ras_n_i(pins.ras_n), .cas_n_i(pins.cas_n), .we_n_i(pins.we_n), .ba_i(pins.ba), .addr_i(pins.addr),
        .odt_i(pins.odt), .dq_i(dat.dq), .dq_o, .dq_oe_o, .dqs_i(dat.dqs), .dqs_n_i(dat.dqs_n), .dqs_o,
        .dqs_oe_o, .dqs_n_o, .dqs_n_oe_o, .dm_rdqs_i(dat.dm), .rdqs_o, .rdqs_oe_o, .rdqs_n_o, .rdqs_n_oe_o,
        .odt_on_o, .clk_on_o);
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // beats follow detected crossings, four clk_i apart
    task automatic rd_chk(input logic [3:0][DQ_W-1:0] e, input logic [2:0] oe);
        int n = 0;
        while (dq_oe_o !== 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        for (int i = 0; i < 4; i++) begin
            chk("dq", dq_o, e[i]);
            chk("dqs", dqs_o, !i[0]);
            chk("dqs_n", dqs_n_o, i[0]);
            chk("rdqs", rdqs_o, !i[0]);
            chk("rdqs_n", rdqs_n_o, i[0]);
            chk("strobe_oe", {dqs_n_oe_o, rdqs_oe_o, rdqs_n_oe_o}, oe);
            repeat (4) @(negedge clk_i);
        end
    endtask
    task automatic no_rd();
        logic seen = 1'b0;
        repeat (24) begin
            @(negedge clk_i);
            seen |= dq_oe_o;
        end
        chk("no_read", seen, 1'b0);
    endtask
    task automatic t_ctl();
        u_ctrl.ctl(1'b1, 1'b1);
        repeat (16) @(negedge clk_i);
        chk("odt_on", odt_on_o, 1'b1);
        chk("clk_on", clk_on_o, 1'b1);
        u_ctrl.ctl(1'b0, 1'b0);
        repeat (16) @(negedge clk_i);
        chk("odt_on", odt_on_o, 1'b0);
        chk("clk_on", clk_on_o, 1'b0);
        u_ctrl.ctl(1'b1, 1'b0);
        $display("test ctl done");
    endtask
    task automatic t_wr_rd();
        u_ctrl.cmd(C_MODE, 2'h0, 13'h0c00);
        u_ctrl.cmd(C_ACT, 2'h2, 13'h1abc);
        u_ctrl.cmd(C_WR, 2'h2, 13'h0004);
        u_ctrl.wr({8'h44, 8'h33, 8'h22, 8'h11}, 4'h2);
        u_ctrl.cmd(C_RD, 2'h2, 13'h0406);
        rd_chk({8'h00, 8'h11, 8'h44, 8'h33}, 3'h4);
        u_ctrl.cmd(C_RD, 2'h2, 13'h0006);
        no_rd();
        u_ctrl.cmd(C_ACT, 2'h2, 13'h0001, 1'b1);
        u_ctrl.cmd(C_RD, 2'h2, 13'h0006);
        no_rd();
        $display("test write read done");
    endtask
    task automatic t_rdqs();
        u_ctrl.cmd(C_MODE, 2'h1, 13'h0c00);
        u_ctrl.cmd(C_ACT, 2'h0, 13'h0000);
        u_ctrl.cmd(C_WR, 2'h0, 13'h0008);
        u_ctrl.wr({8'ha4, 8'hb3, 8'hc2, 8'hd1}, 4'hf);
        u_ctrl.cmd(C_RD, 2'h0, 13'h0408);
        rd_chk({8'ha4, 8'hb3, 8'hc2, 8'hd1}, 3'h2);
        u_ctrl.cmd(C_MODE, 2'h1, 13'h0800);
        u_ctrl.cmd(C_ACT, 2'h1, 13'h0000);
        u_ctrl.cmd(C_PRE, 2'h1, 13'h0000);
        u_ctrl.cmd(C_RD, 2'h1, 13'h0000);
        no_rd();
        u_ctrl.cmd(C_ACT, 2'h1, 13'h0000);
        // refresh with A10 set must not act as precharge all
        u_ctrl.cmd(C_REF, 2'h1, 13'h0400);
        u_ctrl.cmd(C_RD, 2'h1, 13'h0400);
        rd_chk('0, 3'h7);
        $display("test read strobe done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk_i);
        sys_rst_i = 1'b0;
        t_ctl();
        t_wr_rd();
        t_rdqs();
        conclude();
    end
    initial begin
        #200000;
        err_count++;
        conclude();
    end
endmodule // ddr2_sdram_pin_interface_tb_top
